//--- hdl/encoder_channel_monitor_pkg.sv
// constants shared by the encoder channel monitor and its phase engine
package encoder_channel_monitor_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int COUNT_W = 32;
  localparam int LOSS_W = 16;
  localparam int DIV_W = 4;
  localparam int PHASE_W = 16;
  localparam int SOS_W = 33;
  localparam int CORDIC_W = 19;

  // ----------------------------------------------------------------
  // reset values, suited to sinusoidal operation
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] ENC_DIV_RESET = 4'h3;
  localparam logic [DIV_W-1:0] ADC_DIV_RESET = 4'h3;
  localparam logic [31:0] ADC_CTRL_RESET = 32'h3FFFC000;
  localparam logic [23:0] ADC_STROBE_RESET = 24'h3FFFC0;
  localparam logic [7:0] ADC_DELAY_RESET = 8'h00;
  localparam logic [5:0] ADC_HEADER_RESET = 6'h00;
  localparam logic ADC_UTOS_RESET = 1'b0;
  localparam logic AUX_XSTR_RESET = 1'b0;
  localparam logic CLK_SEL_RESET = 1'b0;
  // filter and A/B history start on a normal, complementary pin state
  localparam logic [3:0] PIN_FILT_RESET = 4'h6;
  localparam logic [1:0] AB_PREV_RESET = 2'b10;
  localparam logic [LOSS_W-1:0] LOSS_LIMIT_RESET = 16'h0028;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 50;
  localparam int ENC_SAMPLE_MHZ_DIV0 = 100;
  localparam int QUAD_MAX_MHZ = 10;
  // core cycles between samples at divider zero, never below one
  localparam int ENC_BASE_CYCLES =
    (CORE_CLK_MHZ / ENC_SAMPLE_MHZ_DIV0 < 1) ? 1 : CORE_CLK_MHZ / ENC_SAMPLE_MHZ_DIV0;
  localparam logic [3:0] CORDIC_ITERS = 4'hC;

  // ----------------------------------------------------------------
  // phase engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ROTATE = 2'b01,
    PH_DONE = 2'b10
  } phase_state_t;
endpackage : encoder_channel_monitor_pkg

//--- hdl/sincos_phase.sv
// arctangent phase and sine/cosine amplitude check for one servo sample
module sincos_phase (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // sample in
  input wire logic start,
  input wire logic signed [encoder_channel_monitor_pkg::SAMPLE_W-1:0] sineIn,
  input wire logic signed [encoder_channel_monitor_pkg::SAMPLE_W-1:0] cosineIn,
  input wire logic [encoder_channel_monitor_pkg::SOS_W-1:0] sosExpected,
  input wire logic [encoder_channel_monitor_pkg::SOS_W-1:0] sosTolerance,
  // result out
  output logic [encoder_channel_monitor_pkg::PHASE_W-1:0] phase,
  output logic phaseValid,
  output logic amplitudeBad
);
  localparam int W = encoder_channel_monitor_pkg::CORDIC_W;
  localparam int PW = encoder_channel_monitor_pkg::PHASE_W;
  localparam int SW = encoder_channel_monitor_pkg::SOS_W;

  // angle of atan(2^-i) in units of one turn / 65536
  function automatic logic [PW-1:0] atanStep(input logic [3:0] i);
    logic [PW-1:0] t;
    t = 16'h0000;
    unique case (i)
      4'h0: t = 16'h2000;
      4'h1: t = 16'h12E4;
      4'h2: t = 16'h09FB;
      4'h3: t = 16'h0511;
      4'h4: t = 16'h028B;
      4'h5: t = 16'h0146;
      4'h6: t = 16'h00A3;
      4'h7: t = 16'h0051;
      4'h8: t = 16'h0029;
      4'h9: t = 16'h0014;
      4'hA: t = 16'h000A;
      4'hB: t = 16'h0005;
      default: t = 16'h0000;
    endcase
    return t;
  endfunction : atanStep

  encoder_channel_monitor_pkg::phase_state_t state_reg, state_next;
  logic signed [W-1:0] x_reg, y_reg;
  logic [PW-1:0] z_reg;
  logic [3:0] iter_reg;
  logic [SW-1:0] sos_reg;

  // sum of squares is non-negative, so an unsigned compare is safe
  wire logic [SW-1:0] sos = SW'(sineIn) * SW'(sineIn) + SW'(cosineIn) * SW'(cosineIn);
  wire logic [SW-1:0] sosDiff = (sos_reg > sosExpected) ?
    sos_reg - sosExpected : sosExpected - sos_reg;
  wire logic signed [W-1:0] xs = x_reg >>> iter_reg;
  wire logic signed [W-1:0] ys = y_reg >>> iter_reg;
  wire logic negY = y_reg[W-1];
  wire logic negC = cosineIn[encoder_channel_monitor_pkg::SAMPLE_W-1];
  wire logic lastIter = (iter_reg == encoder_channel_monitor_pkg::CORDIC_ITERS - 4'h1);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      encoder_channel_monitor_pkg::PH_IDLE:
        if (start) state_next = encoder_channel_monitor_pkg::PH_ROTATE;
      encoder_channel_monitor_pkg::PH_ROTATE:
        if (lastIter) state_next = encoder_channel_monitor_pkg::PH_DONE;
      encoder_channel_monitor_pkg::PH_DONE:
        state_next = start ? encoder_channel_monitor_pkg::PH_ROTATE :
          encoder_channel_monitor_pkg::PH_IDLE;
      default: state_next = encoder_channel_monitor_pkg::PH_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // vectoring iterations; a new start restarts the engine unless it lands on the last iteration, which still goes to PH_DONE
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= encoder_channel_monitor_pkg::PH_IDLE;
      x_reg <= '0;
      y_reg <= '0;
      z_reg <= '0;
      iter_reg <= 4'h0;
      sos_reg <= '0;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
      if (start)
      begin
        // left half plane: turn by half a revolution first
        x_reg <= negC ? -W'(cosineIn) : W'(cosineIn);
        y_reg <= negC ? -W'(sineIn) : W'(sineIn);
        z_reg <= negC ? 16'h8000 : 16'h0000;
        iter_reg <= 4'h0;
        sos_reg <= sos;
      end
      else if (state_reg == encoder_channel_monitor_pkg::PH_ROTATE)
      begin
        x_reg <= negY ? x_reg - ys : x_reg + ys;
        y_reg <= negY ? y_reg + xs : y_reg - xs;
        z_reg <= negY ? z_reg - atanStep(iter_reg) : z_reg + atanStep(iter_reg);
        iter_reg <= iter_reg + 4'h1;
      end
    end
  end

  assign phase = z_reg;
  assign phaseValid = (state_reg == encoder_channel_monitor_pkg::PH_DONE);
  assign amplitudeBad = phaseValid && (sosDiff > sosTolerance);
endmodule : sincos_phase

//--- hdl/encoder_channel_monitor.sv
// one encoder channel: loss detection, x4 counting, fine phase and output flags
module encoder_channel_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // encoder pins (asynchronous)
  input wire logic encAPos,
  input wire logic encANeg,
  input wire logic encBPos,
  input wire logic encBNeg,
  // same-domain timing and ADC samples
  input wire logic servoClk,
  input wire logic serialEncClk,
  input wire logic signed [encoder_channel_monitor_pkg::SAMPLE_W-1:0] sineSample,
  input wire logic signed [encoder_channel_monitor_pkg::SAMPLE_W-1:0] cosineSample,
  // configuration load
  input wire logic cfgLoad,
  input wire logic [encoder_channel_monitor_pkg::DIV_W-1:0] cfgEncDivider,
  input wire logic [encoder_channel_monitor_pkg::DIV_W-1:0] cfgAdcDivider,
  input wire logic [31:0] cfgAdcControl,
  input wire logic [23:0] cfgAdcStrobe,
  input wire logic [7:0] cfgAdcDelay,
  input wire logic [5:0] cfgAdcHeader,
  input wire logic cfgAdcUtoS,
  input wire logic cfgAuxTransistor,
  input wire logic cfgClockSelect,
  input wire logic cfgStopEnable,
  input wire logic [encoder_channel_monitor_pkg::LOSS_W-1:0] cfgLossThreshold,
  input wire logic [encoder_channel_monitor_pkg::SOS_W-1:0] sosExpected,
  input wire logic [encoder_channel_monitor_pkg::SOS_W-1:0] sosTolerance,
  // flag clears
  input wire logic lossFlagClear,
  input wire logic amplitudeErrorClear,
  // status
  output logic encoderLossFlag,
  output logic sineCosineAmplitudeError,
  output logic [encoder_channel_monitor_pkg::LOSS_W-1:0] lossEventCounter,
  output logic motorStop,
  output logic [encoder_channel_monitor_pkg::COUNT_W-1:0] capturedCount,
  output logic [encoder_channel_monitor_pkg::COUNT_W+13:0] highResPosition,
  output logic positionValid,
  // ADC settings and sample clocks
  output logic [31:0] adcControlWord,
  output logic [23:0] adcStrobeWord,
  output logic [7:0] adcSampleDelay,
  output logic [5:0] adcHeaderBitCount,
  output logic adcUnsignedToSigned,
  output logic adcSampleTick,
  // auxiliary outputs
  output logic auxTransistorOn,
  output logic clkOutPos,
  output logic clkOutNeg
);
  localparam int CW = encoder_channel_monitor_pkg::COUNT_W;
  localparam int LW = encoder_channel_monitor_pkg::LOSS_W;
  localparam int DW = encoder_channel_monitor_pkg::DIV_W;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // divider counter: reload from the divider when it runs out
  function automatic logic [DW+1:0] divNext(input logic [DW+1:0] cnt, input logic [DW-1:0] div);
    return (cnt == '0) ? (DW+2)'((div + 1'b1) * encoder_channel_monitor_pkg::ENC_BASE_CYCLES - 1)
                       : cnt - 1'b1;
  endfunction : divNext

  // x4 step from previous and present A/B: +1, -1 or 0
  function automatic logic [1:0] quadStep(input logic [1:0] prev, input logic [1:0] cur);
    logic [3:0] k;
    k = {prev, cur};
    unique case (k)
      4'h1, 4'h7, 4'hE, 4'h8: return 2'b01;
      4'h2, 4'hB, 4'hD, 4'h4: return 2'b11;
      default: return 2'b00;
    endcase
  endfunction : quadStep

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [DW-1:0] encDiv_reg, adcDiv_reg;
  logic stopEn_reg;
  logic [LW-1:0] lossLimit_reg;

  // reset defaults for sinusoidal operation
  // sinusoidal reset values
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      encDiv_reg <= encoder_channel_monitor_pkg::ENC_DIV_RESET;
      adcDiv_reg <= encoder_channel_monitor_pkg::ADC_DIV_RESET;
      adcControlWord <= encoder_channel_monitor_pkg::ADC_CTRL_RESET;
      adcStrobeWord <= encoder_channel_monitor_pkg::ADC_STROBE_RESET;
      adcSampleDelay <= encoder_channel_monitor_pkg::ADC_DELAY_RESET;
      adcHeaderBitCount <= encoder_channel_monitor_pkg::ADC_HEADER_RESET;
      adcUnsignedToSigned <= encoder_channel_monitor_pkg::ADC_UTOS_RESET;
      auxTransistorOn <= encoder_channel_monitor_pkg::AUX_XSTR_RESET;
      stopEn_reg <= 1'b0;
      lossLimit_reg <= encoder_channel_monitor_pkg::LOSS_LIMIT_RESET;
    end
    else if (clkEn && cfgLoad)
    begin
      encDiv_reg <= cfgEncDivider;
      adcDiv_reg <= cfgAdcDivider;
      adcControlWord <= cfgAdcControl;
      adcStrobeWord <= cfgAdcStrobe;
      adcSampleDelay <= cfgAdcDelay;
      adcHeaderBitCount <= cfgAdcHeader;
      adcUnsignedToSigned <= cfgAdcUtoS;
      auxTransistorOn <= cfgAuxTransistor;
      stopEn_reg <= cfgStopEnable;
      lossLimit_reg <= cfgLossThreshold;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and agreement filter
  // ----------------------------------------------------------------
  logic [3:0] pinMeta_reg, pinSync1_reg, pinSync2_reg, pinFilt_reg;
  logic [DW+1:0] encCnt_reg, adcCnt_reg;
  logic servoPrev_reg, clkSel_reg;
  wire logic [3:0] pinRaw = {encBNeg, encBPos, encANeg, encAPos};
  wire logic [3:0] pinAgree = ~(pinSync1_reg ^ pinSync2_reg);
  wire logic [3:0] pinFiltNext = (pinAgree & pinSync2_reg) | (~pinAgree & pinFilt_reg);
  wire logic encSampleTick = (encCnt_reg == '0);
  wire logic servoEvent = servoClk && !servoPrev_reg;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta_reg <= encoder_channel_monitor_pkg::PIN_FILT_RESET;
      pinSync1_reg <= encoder_channel_monitor_pkg::PIN_FILT_RESET;
      pinSync2_reg <= encoder_channel_monitor_pkg::PIN_FILT_RESET;
      pinFilt_reg <= encoder_channel_monitor_pkg::PIN_FILT_RESET;
      encCnt_reg <= '0;
      adcCnt_reg <= '0;
      servoPrev_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      pinMeta_reg <= pinRaw;
      pinSync1_reg <= pinMeta_reg;
      pinSync2_reg <= pinSync1_reg;
      pinFilt_reg <= pinFiltNext;
      encCnt_reg <= divNext(encCnt_reg, encDiv_reg);
      adcCnt_reg <= divNext(adcCnt_reg, adcDiv_reg);
      servoPrev_reg <= servoClk;
    end
  end

  assign adcSampleTick = (adcCnt_reg == '0);

  // ----------------------------------------------------------------
  // loss detection and counting
  // ----------------------------------------------------------------
  // equal levels on a pair
  wire logic lossNow = (pinFilt_reg[0] == pinFilt_reg[1]) || (pinFilt_reg[2] == pinFilt_reg[3]);
  wire logic lossAtMax = (lossEventCounter == {LW{1'b1}});
  wire logic lossAtZero = (lossEventCounter == '0);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      encoderLossFlag <= 1'b0;
      lossEventCounter <= '0;
      motorStop <= 1'b0;
    end
    else if (clkEn)
    begin
      encoderLossFlag <= lossNow || (encoderLossFlag && !lossFlagClear);
      if (servoEvent)
      begin
        // up on loss, down to zero otherwise
        if (lossNow && !lossAtMax)
          lossEventCounter <= lossEventCounter + 1'b1;
        else if (!lossNow && !lossAtZero)
          lossEventCounter <= lossEventCounter - 1'b1;
      end
      // stop above threshold; cleared once the counter falls back
      motorStop <= stopEn_reg && (lossEventCounter > lossLimit_reg);
    end
  end

  // ----------------------------------------------------------------
  // x4 counting, capture and fine phase
  // ----------------------------------------------------------------
  logic [1:0] abPrev_reg;
  logic [CW-1:0] count_reg;
  wire logic [1:0] abNow = {pinFilt_reg[2], pinFilt_reg[0]};
  wire logic [1:0] step = quadStep(abPrev_reg, abNow);
  wire logic [15:0] finePhase;
  wire logic phaseValid;
  wire logic amplitudeBad;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      abPrev_reg <= encoder_channel_monitor_pkg::AB_PREV_RESET;
      count_reg <= '0;
      capturedCount <= '0;
      highResPosition <= '0;
      positionValid <= 1'b0;
      sineCosineAmplitudeError <= 1'b0;
      clkSel_reg <= encoder_channel_monitor_pkg::CLK_SEL_RESET;
      clkOutPos <= 1'b0;
      clkOutNeg <= 1'b1;
    end
    else if (clkEn)
    begin
      // counting is suspended while loss is seen
      if (encSampleTick && !lossNow)
      begin
        abPrev_reg <= abNow;
        count_reg <= count_reg + {{(CW-2){step[1]}}, step};
      end
      if (servoEvent)
        capturedCount <= count_reg;
      if (phaseValid)
        highResPosition <= {capturedCount[CW-1:2], finePhase};
      positionValid <= phaseValid;
      // amplitude error, set wins over clear
      sineCosineAmplitudeError <= amplitudeBad ||
        (sineCosineAmplitudeError && !amplitudeErrorClear);
      if (cfgLoad)
        clkSel_reg <= cfgClockSelect;
      clkOutPos <= clkSel_reg ? servoClk : serialEncClk;
      clkOutNeg <= clkSel_reg ? !servoClk : !serialEncClk;
    end
  end

  // phase from samples taken at the servo event
  sincos_phase phaseEngine (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .start(servoEvent),
    .sineIn(sineSample),
    .cosineIn(cosineSample),
    .sosExpected(sosExpected),
    .sosTolerance(sosTolerance),
    .phase(finePhase),
    .phaseValid(phaseValid),
    .amplitudeBad(amplitudeBad)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_loss_count_up: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && servoEvent && lossNow && !lossAtMax |=> lossEventCounter == $past(lossEventCounter) + 1'b1)
    else $error("loss counter did not count up");
  chk_loss_count_down: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && servoEvent && !lossNow && !lossAtZero |=>
      lossEventCounter == $past(lossEventCounter) - 1'b1)
    else $error("loss counter did not count down");
  chk_loss_floor: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && servoEvent && !lossNow && lossAtZero |=> lossEventCounter == '0)
    else $error("loss counter left zero without loss");
  chk_count_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !servoEvent |=> $stable(lossEventCounter))
    else $error("loss counter moved between servo events");
  chk_stop_limit: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn ##1 clkEn |-> motorStop == $past(stopEn_reg && lossEventCounter > lossLimit_reg))
    else $error("stop output disagrees with threshold");
  chk_loss_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && lossNow |=> encoderLossFlag)
    else $error("loss flag not set");
  chk_pair_loss: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && lossFlagClear && (pinFilt_reg[0] ^ pinFilt_reg[1]) &&
      (pinFilt_reg[2] ^ pinFilt_reg[3]) |=> !encoderLossFlag)
    else $error("loss flag held on complementary pairs");
  chk_amp_error: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && amplitudeBad |=> sineCosineAmplitudeError)
    else $error("amplitude error not set");
  chk_capture_count: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && servoEvent |=> capturedCount == $past(count_reg))
    else $error("count not captured at servo event");
  chk_clock_route: assert property (@(posedge core_clk) disable iff (!rst_b)
    clkEn && !clkSel_reg |=> clkOutPos == $past(serialEncClk))
    else $error("serial clock not routed out");
endmodule : encoder_channel_monitor

//--- verification/quad_encoder_model.sv
// encoder model: differential quadrature pins and sine/cosine ADC samples
module quad_encoder_model (
  // bench control
  input wire logic step,
  input wire logic detached,
  input wire logic signed [15:0] sineLevel,
  input wire logic signed [15:0] cosineLevel,
  // encoder pins and ADC samples
  output logic encAPos,
  output logic encANeg,
  output logic encBPos,
  output logic encBNeg,
  output logic signed [15:0] sineSample,
  output logic signed [15:0] cosineSample
);
  timeunit 1ns;
  timeprecision 1ps;

  // starts where the monitor's pin filter resets, so no step is seen at release
  logic [1:0] phase = 2'h3;
  logic phA;
  logic phB;

  // each step advances a quarter period with A leading B
  always @(posedge step)
  begin
    phase <= phase + 2'h1;
  end

  assign phA = phase[0] ^ phase[1];
  assign phB = phase[1];

  // differential wiring only
  // a detached cable lets the pull-ups take both lines of a pair high
  assign encAPos = detached ? 1'b1 : phA;
  assign encANeg = detached ? 1'b1 : ~phA;
  assign encBPos = detached ? 1'b1 : phB;
  assign encBNeg = detached ? 1'b1 : ~phB;
  assign sineSample = sineLevel;
  assign cosineSample = cosineLevel;
endmodule : quad_encoder_model

//--- verification/encoder_channel_monitor_test.sv
// self-checking bench for the encoder channel monitor
module encoder_channel_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic servoClk = 1'b0;
  logic serialEncClk = 1'b0;
  logic step = 1'b0;
  logic detached = 1'b0;
  logic signed [15:0] sineLevel = 16'h0000;
  logic signed [15:0] cosineLevel = 16'h4000;
  logic clkEn = 1'b1;
  logic cfgLoad = 1'b0;
  logic [3:0] encDiv = 4'h3;
  logic [3:0] adcDiv = 4'h3;
  logic auxOn = 1'b0;
  logic clkSel = 1'b0;
  logic stopEn = 1'b0;
  logic [15:0] lossLimit = 16'h0028;
  logic [32:0] sosExp = 33'h010000000;
  logic [32:0] sosTol = 33'h000100000;
  logic lossClr = 1'b0;
  logic ampClr = 1'b0;
  logic encAPos, encANeg, encBPos, encBNeg;
  logic signed [15:0] sineSample, cosineSample;
  logic lossFlag, ampErr, motorStop, posValid, adcTick, auxTransistorOn, clkOutPos, clkOutNeg;
  logic [15:0] lossCount;
  logic [31:0] capCount, adcControlWord;
  logic [45:0] highRes;
  logic [23:0] adcStrobeWord;
  logic [7:0] adcSampleDelay;
  logic [5:0] adcHeaderBitCount;
  logic adcUnsignedToSigned;
  int failCount = 0;
  int nCompared = 0;

  always #10 core_clk = ~core_clk;

  quad_encoder_model encoder (.step(step), .detached(detached), .sineLevel(sineLevel),
    .cosineLevel(cosineLevel), .encAPos(encAPos), .encANeg(encANeg), .encBPos(encBPos),
    .encBNeg(encBNeg), .sineSample(sineSample), .cosineSample(cosineSample));

  encoder_channel_monitor dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .encAPos(encAPos), .encANeg(encANeg), .encBPos(encBPos), .encBNeg(encBNeg),
    .servoClk(servoClk), .serialEncClk(serialEncClk), .sineSample(sineSample),
    .cosineSample(cosineSample), .cfgLoad(cfgLoad), .cfgEncDivider(encDiv),
    .cfgAdcDivider(adcDiv), .cfgAdcControl(32'h3FFFC000), .cfgAdcStrobe(24'h3FFFC0),
    .cfgAdcDelay(8'h00), .cfgAdcHeader(6'h00), .cfgAdcUtoS(1'b0),
    .cfgAuxTransistor(auxOn), .cfgClockSelect(clkSel), .cfgStopEnable(stopEn),
    .cfgLossThreshold(lossLimit), .sosExpected(sosExp), .sosTolerance(sosTol),
    .lossFlagClear(lossClr), .amplitudeErrorClear(ampClr), .encoderLossFlag(lossFlag),
    .sineCosineAmplitudeError(ampErr), .lossEventCounter(lossCount), .motorStop(motorStop),
    .capturedCount(capCount), .highResPosition(highRes), .positionValid(posValid),
    .adcControlWord(adcControlWord), .adcStrobeWord(adcStrobeWord),
    .adcSampleDelay(adcSampleDelay), .adcHeaderBitCount(adcHeaderBitCount),
    .adcUnsignedToSigned(adcUnsignedToSigned), .adcSampleTick(adcTick),
    .auxTransistorOn(auxTransistorOn), .clkOutPos(clkOutPos), .clkOutNeg(clkOutNeg));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // inputs always change 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    nCompared++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      failCount++;
    end
  endtask : check

  // servoClk stays low a cycle so the next rising edge counts as a new event
  task automatic servo();
    servoClk = 1'b1;
    tick(1);
    servoClk = 1'b0;
    tick(1);
  endtask : servo

  task automatic load();
    cfgLoad = 1'b1;
    tick(1);
    cfgLoad = 1'b0;
    tick(2);
  endtask : load

  // bounded wait for the phase engine result
  task automatic wait_position();
    int k;
    k = 0;
    while (posValid !== 1'b1 && k < 20)
    begin
      tick(1);
      k++;
    end
    check("positionValid", 1, posValid);
  endtask : wait_position

  task automatic summarize();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    int ticks;
    ticks = 0;
    check("adcControlWord", 32'h3FFFC000, adcControlWord);
    check("adcStrobeWord", 24'h3FFFC0, adcStrobeWord);
    check("adcDelayHdrUtoS", 15'h0000,
      {adcSampleDelay, adcHeaderBitCount, adcUnsignedToSigned});
    check("auxTransistorOn", 0, auxTransistorOn);
    repeat (16)
    begin
      tick(1);
      ticks += (adcTick === 1'b1) ? 1 : 0;
    end
    check("adcTickCount", 4, ticks);
    $display("test reset done");
  endtask : test_reset

  task automatic test_count_phase();
    // a step every 8 cycles is seen by the reset sample divider of 3
    repeat (8)
    begin
      step = 1'b1;
      tick(4);
      step = 1'b0;
      tick(4);
    end
    tick(6);
    servo();
    check("capturedCount", 8, capCount);
    wait_position();
    check("positionCount", 30'h2, highRes[45:16]);
    check("phaseNearZero", 1, (highRes[15:0] + 16'h0010) < 16'h0020);
    check("amplitudeOk", 0, ampErr);
    cosineLevel = 16'h1000;
    servo();
    wait_position();
    check("amplitudeBad", 1, ampErr);
    ampClr = 1'b1;
    tick(1);
    ampClr = 1'b0;
    check("amplitudeClear", 0, ampErr);
    // a quarter turn; the amplitude stays on its constant
    sineLevel = 16'h4000;
    cosineLevel = 16'h0000;
    // divider zero must keep up with edges 40 ns apart
    encDiv = 4'h0;
    load();
    repeat (8)
    begin
      step = 1'b1;
      tick(1);
      step = 1'b0;
      tick(1);
    end
    tick(6);
    servo();
    check("fastCount", 16, capCount);
    wait_position();
    check("positionFast", 30'h4, highRes[45:16]);
    check("phaseQuarter", 1, (highRes[15:0] - 16'h3FF0) < 16'h0020);
    check("amplitudeQuarter", 0, ampErr);
    $display("test count and phase done");
  endtask : test_count_phase

  task automatic test_loss();
    lossLimit = 16'h0028;
    stopEn = 1'b1;
    load();
    detached = 1'b1;
    tick(6);
    check("lossFlagSet", 1, lossFlag);
    repeat (40) servo();
    tick(1);
    check("lossCount40", 40, lossCount);
    check("stopAtLimit", 0, motorStop);
    servo();
    tick(1);
    check("stopAboveLimit", 1, motorStop);
    detached = 1'b0;
    tick(6);
    lossClr = 1'b1;
    tick(1);
    lossClr = 1'b0;
    tick(2);
    check("lossFlagClear", 0, lossFlag);
    repeat (45) servo();
    tick(1);
    check("lossCountFloor", 0, lossCount);
    check("stopReleased", 0, motorStop);
    $display("test loss done");
  endtask : test_loss

  task automatic test_outputs();
    auxOn = 1'b1;
    serialEncClk = 1'b1;
    load();
    check("auxTransistorOn", 1, auxTransistorOn);
    check("clkOutSerial", 2'b10, {clkOutPos, clkOutNeg});
    clkSel = 1'b1;
    load();
    check("clkOutServo", 2'b01, {clkOutPos, clkOutNeg});
    // clock enable low freezes state, so this load must not land
    clkEn = 1'b0;
    auxOn = 1'b0;
    load();
    check("auxFrozen", 1, auxTransistorOn);
    clkEn = 1'b1;
    $display("test outputs done");
  endtask : test_outputs

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    tick(12);
    rst_b = 1'b1;
    tick(1);
    test_reset();
    test_count_phase();
    test_loss();
    test_outputs();
    summarize();
  end

  // the tests need about 370 cycles
  initial
  begin
    #100000;
    failCount++;
    summarize();
  end
endmodule : encoder_channel_monitor_test
